// file: hdl/mlsp_regs.vh
`ifndef MLSP_REGS_VH
`define MLSP_REGS_VH

// ----------------------------------------------------------------
// Register bit positions
// ----------------------------------------------------------------
`define MLSP_SR1_SWD_BIT   7
`define MLSP_CR2_TWO_BIT   4
`define MLSP_CR2_FOUR_BIT  6

// ----------------------------------------------------------------
// Address and byte geometry
// ----------------------------------------------------------------
`define MLSP_ADDR_BITS     21
`define MLSP_ADDR_LAST     2'h2
`define MLSP_BYTE_BITS     4'h8

// ----------------------------------------------------------------
// Lane widths (bits moved per edge), decoder lane selects and output enable masks
// ----------------------------------------------------------------
`define MLSP_W1            3'h1
`define MLSP_W2            3'h2
`define MLSP_W4            3'h4
`define MLSP_SEL_2         2'h1
`define MLSP_SEL_4         2'h2
`define MLSP_MASK_1        4'h2
`define MLSP_MASK_2        4'h3
`define MLSP_MASK_4        4'hf

// ----------------------------------------------------------------
// Serial clock limits
// ----------------------------------------------------------------
`define MLSP_SDR_MAX_MHZ   108
`define MLSP_DDR_MAX_MHZ   46

`endif

// file: hdl/mlsp_serial_port.v
`timescale 1ns/1ps
`include "mlsp_regs.vh"

module mlsp_serial_port #(
  parameter ADDR_W = `MLSP_ADDR_BITS
) (
  input  wire              sys_clk_in,
  input  wire              rst_in,
  input  wire              cs_n_in,
  input  wire              sck_in,
  input  wire              lane_zero_in,
  input  wire              lane_one_in,
  input  wire              lane_two_in,
  input  wire              lane_three_in,
  output wire              lane_zero_out,
  output wire              lane_zero_oe_out,
  output wire              lane_one_out,
  output wire              lane_one_oe_out,
  output wire              lane_two_out,
  output wire              lane_two_oe_out,
  output wire              lane_three_out,
  output wire              lane_three_oe_out,
  input  wire [7:0]        first_status_register_in,
  input  wire [7:0]        second_config_register_nv_in,
  input  wire              cfg_vol_we_in,
  input  wire [7:0]        cfg_vol_data_in,
  output wire              two_lane_all_phase_protocol_out,
  output wire              four_lane_all_phase_protocol_out,
  output wire              standby_out,
  output wire              hw_reset_out,
  output wire              cmd_valid_out,
  output wire [7:0]        cmd_opcode_out,
  input  wire              dec_has_addr_in,
  input  wire              dec_addr_wide_in,
  input  wire [1:0]        dec_data_lanes_in,
  input  wire              dec_ddr_in,
  input  wire              dec_read_in,
  input  wire [3:0]        dec_dummy_in,
  input  wire              dec_status_write_in,
  output wire              addr_valid_out,
  output wire [ADDR_W-1:0] addr_out,
  output wire              wr_valid_out,
  output wire [7:0]        wr_data_out,
  output wire              rd_req_out,
  input  wire [7:0]        rd_data_in,
  output wire              reg_write_blocked_out
);

  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_OPC   = 3'h1;
  localparam [2:0] ST_DEC   = 3'h2;
  localparam [2:0] ST_ADDR  = 3'h3;
  localparam [2:0] ST_DUMMY = 3'h4;
  localparam [2:0] ST_WDATA = 3'h5;
  localparam [2:0] ST_RDATA = 3'h6;
  localparam [2:0] ST_DONE  = 3'h7;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function [7:0] shift_in;
    input [7:0] sh;
    input [3:0] l;
    input [2:0] w;
    begin
      case (w)
        `MLSP_W4: shift_in = {sh[3:0], l};
        `MLSP_W2: shift_in = {sh[5:0], l[1:0]};
        default:  shift_in = {sh[6:0], l[0]};
      endcase
    end
  endfunction

  function [3:0] lanes_of;
    input [7:0] b;
    input [2:0] w;
    begin
      case (w)
        `MLSP_W4: lanes_of = b[7:4];
        `MLSP_W2: lanes_of = {2'h0, b[7:6]};
        default:  lanes_of = {2'h0, b[7], 1'b0};
      endcase
    end
  endfunction

  function [3:0] oe_mask;
    input [2:0] w;
    begin
      case (w)
        `MLSP_W4: oe_mask = `MLSP_MASK_4;
        `MLSP_W2: oe_mask = `MLSP_MASK_2;
        default:  oe_mask = `MLSP_MASK_1;
      endcase
    end
  endfunction

  function [2:0] sel_width;
    input [1:0] sel;
    begin
      case (sel)
        `MLSP_SEL_4: sel_width = `MLSP_W4;
        `MLSP_SEL_2: sel_width = `MLSP_W2;
        default:     sel_width = `MLSP_W1;
      endcase
    end
  endfunction

  function [2:0] after_addr;
    input [3:0] dummy;
    input       rd;
    begin
      if (dummy != 4'h0)
        after_addr = ST_DUMMY;
      else if (rd)
        after_addr = ST_RDATA;
      else
        after_addr = ST_WDATA;
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers and serial clock edges
  // ----------------------------------------------------------------
  reg  [5:0] sync1_reg;
  reg  [5:0] sync2_reg;
  reg        sck_prev_reg;

  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_reg    <= 6'h3f;
      sync2_reg    <= 6'h3f;
      sck_prev_reg <= 1'b1;
    end else begin
      sync1_reg    <= {cs_n_in, sck_in, lane_three_in, lane_two_in, lane_one_in, lane_zero_in};
      sync2_reg    <= sync1_reg;
      sck_prev_reg <= sync2_reg[4];
    end
  end

  wire       cs_n_s = sync2_reg[5];
  wire [3:0] lanes_s = sync2_reg[3:0];
  wire       rise = sync2_reg[4] & ~sck_prev_reg;
  wire       fall = ~sync2_reg[4] & sck_prev_reg;

  // ----------------------------------------------------------------
  // Pin roles, protection and volatile configuration
  // ----------------------------------------------------------------
  reg        two_all_reg;
  reg        four_all_reg;
  reg        reload_reg;
  reg        quad_cmd_reg;
  reg  [1:0] quad_lag_reg;

  // Lanes two and three keep their data role until the synchronisers have flushed
  // the last driven value, so a low data bit is never taken for a reset pulse
  wire       quad_pins = four_all_reg | quad_cmd_reg | (|quad_lag_reg);

  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      quad_lag_reg <= 2'h0;
    end else begin
      quad_lag_reg <= {quad_lag_reg[0], four_all_reg | quad_cmd_reg};
    end
  end
  wire       hw_rst = ~quad_pins & ~lanes_s[3];
  wire       protect = ~quad_pins & ~lanes_s[2] &
                       first_status_register_in[`MLSP_SR1_SWD_BIT];
  wire [2:0] proto_w = four_all_reg ? `MLSP_W4 :
                       (two_all_reg ? `MLSP_W2 : `MLSP_W1);

  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      two_all_reg  <= 1'b0;
      four_all_reg <= 1'b0;
      reload_reg   <= 1'b1;
    end else if (hw_rst) begin
      reload_reg   <= 1'b1;
    end else if (reload_reg) begin
      two_all_reg  <= second_config_register_nv_in[`MLSP_CR2_TWO_BIT];
      four_all_reg <= second_config_register_nv_in[`MLSP_CR2_FOUR_BIT];
      reload_reg   <= 1'b0;
    end else if (cfg_vol_we_in && !protect) begin
      two_all_reg  <= cfg_vol_data_in[`MLSP_CR2_TWO_BIT];
      four_all_reg <= cfg_vol_data_in[`MLSP_CR2_FOUR_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  reg  [2:0]        state_reg;
  reg  [7:0]        sh_reg;
  reg  [3:0]        cnt_reg;
  reg  [1:0]        byte_cnt_reg;
  reg  [15:0]       addr_hi_reg;
  reg  [2:0]        w_reg;
  reg  [2:0]        data_w_reg;
  reg               ddr_reg;
  reg               rd_reg;
  reg  [3:0]        dummy_reg;
  reg               block_reg;
  reg  [7:0]        out_sh_reg;
  reg  [3:0]        out_cnt_reg;
  reg               out_on_reg;
  reg  [3:0]        lane_out_reg;
  reg               standby_reg;
  reg               cmd_valid_reg;
  reg  [7:0]        opcode_reg;
  reg               addr_valid_reg;
  reg  [ADDR_W-1:0] addr_out_reg;
  reg               wr_valid_reg;
  reg  [7:0]        wr_data_reg;
  reg               rd_req_reg;

  wire        in_evt = rise | (ddr_reg & fall);
  wire        out_evt = fall | (ddr_reg & rise);
  wire [7:0]  sh_next = shift_in(sh_reg, lanes_s, w_reg);
  wire [3:0]  cnt_sum = cnt_reg + {1'b0, w_reg};
  wire        byte_done = (cnt_sum == `MLSP_BYTE_BITS);
  wire [3:0]  out_sum = out_cnt_reg + {1'b0, data_w_reg};
  wire [23:0] addr_full = {addr_hi_reg, sh_next};
  wire [2:0]  dec_dw = (proto_w != `MLSP_W1) ? proto_w : sel_width(dec_data_lanes_in);
  wire [2:0]  dec_aw = (proto_w != `MLSP_W1) ? proto_w :
                       (dec_addr_wide_in ? dec_dw : `MLSP_W1);

  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg      <= ST_IDLE;
      sh_reg         <= 8'h00;
      cnt_reg        <= 4'h0;
      byte_cnt_reg   <= 2'h0;
      addr_hi_reg    <= 16'h0000;
      w_reg          <= `MLSP_W1;
      data_w_reg     <= `MLSP_W1;
      ddr_reg        <= 1'b0;
      rd_reg         <= 1'b0;
      dummy_reg      <= 4'h0;
      block_reg      <= 1'b0;
      out_sh_reg     <= 8'h00;
      out_cnt_reg    <= 4'h0;
      out_on_reg     <= 1'b0;
      lane_out_reg   <= 4'h0;
      quad_cmd_reg   <= 1'b0;
      standby_reg    <= 1'b1;
      cmd_valid_reg  <= 1'b0;
      opcode_reg     <= 8'h00;
      addr_valid_reg <= 1'b0;
      addr_out_reg   <= {ADDR_W{1'b0}};
      wr_valid_reg   <= 1'b0;
      wr_data_reg    <= 8'h00;
      rd_req_reg     <= 1'b0;
    end else begin
      cmd_valid_reg  <= 1'b0;
      addr_valid_reg <= 1'b0;
      wr_valid_reg   <= 1'b0;
      rd_req_reg     <= 1'b0;
      standby_reg    <= cs_n_s;
      if (hw_rst) begin
        state_reg    <= cs_n_s ? ST_IDLE : ST_DONE;
        out_on_reg   <= 1'b0;
        quad_cmd_reg <= 1'b0;
        ddr_reg      <= 1'b0;
        block_reg    <= 1'b0;
      end else if (cs_n_s) begin
        state_reg    <= ST_IDLE;
        out_on_reg   <= 1'b0;
        quad_cmd_reg <= 1'b0;
        ddr_reg      <= 1'b0;
        block_reg    <= 1'b0;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            state_reg    <= ST_OPC;
            w_reg        <= proto_w;
            cnt_reg      <= 4'h0;
            byte_cnt_reg <= 2'h0;
            block_reg    <= 1'b0;
          end
          ST_OPC: begin
            if (rise) begin
              sh_reg  <= sh_next;
              cnt_reg <= byte_done ? 4'h0 : cnt_sum;
              if (byte_done) begin
                opcode_reg    <= sh_next;
                cmd_valid_reg <= 1'b1;
                state_reg     <= ST_DEC;
              end
            end
          end
          ST_DEC: begin
            data_w_reg   <= dec_dw;
            w_reg        <= dec_aw;
            quad_cmd_reg <= (dec_dw == `MLSP_W4);
            ddr_reg      <= dec_ddr_in;
            rd_reg       <= dec_read_in;
            dummy_reg    <= dec_dummy_in;
            block_reg    <= dec_status_write_in & protect;
            out_cnt_reg  <= 4'h0;
            if (dec_has_addr_in) begin
              state_reg <= ST_ADDR;
            end else begin
              state_reg  <= after_addr(dec_dummy_in, dec_read_in);
              w_reg      <= dec_dw;
              rd_req_reg <= dec_read_in & (dec_dummy_in == 4'h0);
            end
          end
          ST_ADDR: begin
            if (in_evt) begin
              sh_reg  <= sh_next;
              cnt_reg <= byte_done ? 4'h0 : cnt_sum;
              if (byte_done) begin
                addr_hi_reg  <= addr_full[15:0];
                byte_cnt_reg <= byte_cnt_reg + 2'h1;
                if (byte_cnt_reg == `MLSP_ADDR_LAST) begin
                  addr_out_reg   <= addr_full[ADDR_W-1:0];
                  addr_valid_reg <= 1'b1;
                  w_reg          <= data_w_reg;
                  state_reg      <= after_addr(dummy_reg, rd_reg);
                  rd_req_reg     <= rd_reg & (dummy_reg == 4'h0);
                end
              end
            end
          end
          ST_DUMMY: begin
            if (rise) begin
              dummy_reg <= dummy_reg - 4'h1;
              if (dummy_reg == 4'h1) begin
                state_reg  <= rd_reg ? ST_RDATA : ST_WDATA;
                rd_req_reg <= rd_reg;
              end
            end
          end
          ST_WDATA: begin
            if (in_evt) begin
              sh_reg  <= sh_next;
              cnt_reg <= byte_done ? 4'h0 : cnt_sum;
              if (byte_done && !block_reg) begin
                wr_data_reg  <= sh_next;
                wr_valid_reg <= 1'b1;
              end
            end
          end
          ST_RDATA: begin
            if (out_evt) begin
              out_on_reg  <= 1'b1;
              out_cnt_reg <= (out_sum == `MLSP_BYTE_BITS) ? 4'h0 : out_sum;
              rd_req_reg  <= (out_sum == `MLSP_BYTE_BITS);
              if (out_cnt_reg == 4'h0) begin
                lane_out_reg <= lanes_of(rd_data_in, data_w_reg);
                out_sh_reg   <= rd_data_in << data_w_reg;
              end else begin
                lane_out_reg <= lanes_of(out_sh_reg, data_w_reg);
                out_sh_reg   <= out_sh_reg << data_w_reg;
              end
            end
          end
          ST_DONE: begin
            state_reg <= ST_DONE;
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  wire [3:0] lane_oe = {4{out_on_reg}} & oe_mask(data_w_reg);

  assign lane_zero_out                    = lane_out_reg[0];
  assign lane_zero_oe_out                 = lane_oe[0];
  assign lane_one_out                     = lane_out_reg[1];
  assign lane_one_oe_out                  = lane_oe[1];
  assign lane_two_out                     = lane_out_reg[2];
  assign lane_two_oe_out                  = lane_oe[2];
  assign lane_three_out                   = lane_out_reg[3];
  assign lane_three_oe_out                = lane_oe[3];
  assign two_lane_all_phase_protocol_out  = two_all_reg;
  assign four_lane_all_phase_protocol_out = four_all_reg;
  assign standby_out                      = standby_reg;
  assign hw_reset_out                     = hw_rst;
  assign cmd_valid_out                    = cmd_valid_reg;
  assign cmd_opcode_out                   = opcode_reg;
  assign addr_valid_out                   = addr_valid_reg;
  assign addr_out                         = addr_out_reg;
  assign wr_valid_out                     = wr_valid_reg;
  assign wr_data_out                      = wr_data_reg;
  assign rd_req_out                       = rd_req_reg;
  assign reg_write_blocked_out            = block_reg;

endmodule

// file: tb/mlsp_checker.sv
`timescale 1ns/1ps
module mlsp_checker (
  input wire       sys_clk_in,
  input wire       rst_in,
  input wire       cs_n_in,
  input wire       sck_in,
  input wire       lane_two_in,
  input wire       lane_three_in,
  input wire       lane_zero_oe_out,
  input wire       lane_one_out,
  input wire       lane_one_oe_out,
  input wire       lane_two_oe_out,
  input wire       lane_three_oe_out,
  input wire [7:0] first_status_register_in,
  input wire [7:0] second_config_register_nv_in,
  input wire       cfg_vol_we_in,
  input wire [7:0] cfg_vol_data_in,
  input wire       two_lane_all_phase_protocol_out,
  input wire       four_lane_all_phase_protocol_out,
  input wire       standby_out,
  input wire       hw_reset_out,
  input wire       cmd_valid_out,
  input wire       wr_valid_out,
  input wire       reg_write_blocked_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  reg        seen_reg;
  wire [3:0] oe_w = {lane_three_oe_out, lane_two_oe_out, lane_one_oe_out, lane_zero_oe_out};
  // Marks an opcode already taken in the current select
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      seen_reg <= 1'b0;
    end else if (standby_out) begin
      seen_reg <= 1'b0;
    end else if (cmd_valid_out) begin
      seen_reg <= 1'b1;
    end
  end
  property p_idle;
    cs_n_in [*4] |-> standby_out;
  endproperty
  a_idle: assert property (p_idle) else $error("standby missing while deselected");
  property p_quiet;
    cs_n_in [*6] |-> oe_w == 4'h0;
  endproperty
  a_quiet: assert property (p_quiet) else $error("lane driven while deselected");
  property p_fall;
    lane_one_oe_out && $changed(lane_one_out) |-> !sck_in && !$past(sck_in, 2);
  endproperty
  a_fall: assert property (p_fall) else $error("output changed outside clock low phase");
  property p_one;
    cmd_valid_out |-> !seen_reg;
  endproperty
  a_one: assert property (p_one) else $error("second opcode in one select");
  property p_blk;
    reg_write_blocked_out |-> !wr_valid_out;
  endproperty
  a_blk: assert property (p_blk) else $error("blocked write delivered data");
  property p_why;
    $rose(reg_write_blocked_out) |-> first_status_register_in[7] && !lane_two_in;
  endproperty
  a_why: assert property (p_why) else $error("write blocked without protection");
  property p_cfg;
    cfg_vol_we_in && cfg_vol_data_in[4] && lane_two_in && !hw_reset_out && !four_lane_all_phase_protocol_out
      |=> two_lane_all_phase_protocol_out;
  endproperty
  a_cfg: assert property (p_cfg) else $error("volatile config write lost");
  property p_hw;
    (standby_out && !lane_three_in && !four_lane_all_phase_protocol_out) [*4] |-> hw_reset_out;
  endproperty
  a_hw: assert property (p_hw) else $error("reset pin low not seen");
  property p_mute;
    hw_reset_out [*3] |-> oe_w == 4'h0;
  endproperty
  a_mute: assert property (p_mute) else $error("lane driven during pin reset");
  property p_load;
    $fell(hw_reset_out) |-> ##[1:3] two_lane_all_phase_protocol_out == second_config_register_nv_in[4];
  endproperty
  a_load: assert property (p_load) else $error("config not reloaded after pin reset");
endmodule

bind mlsp_serial_port mlsp_checker u_mlsp_checker (.*);

// file: tb/mlsp_master_model.sv
`timescale 1ns/1ps
module mlsp_master_model (
  output logic       cs_n_out,
  output logic       sck_out,
  output logic [3:0] lane_out,
  output logic [3:0] lane_oe_out,
  input  wire  [3:0] lane_in
);
  logic mode3;
  initial begin
    {cs_n_out, sck_out, mode3} = 3'h4;
    lane_out = 4'h0;
    lane_oe_out = 4'h0;
  end
  // Clock parks at its idle level before select falls
  task start(input logic m3);
    mode3 = m3;
    sck_out = m3;
    #40 cs_n_out = 1'b0;
    #40;
  endtask
  // Lanes change with the fall, bits are taken at the rise
  task xfer(input logic [7:0] b, input int w, input logic rx, output logic [7:0] r);
    logic [3:0] m;
    logic [3:0] g;
    m = (w == 4) ? 4'hf : (w == 2) ? 4'h3 : 4'h1;
    r = 8'h00;
    for (int i = 8 / w - 1; i >= 0; i--) begin
      sck_out = 1'b0;
      lane_out = 4'(b >> (i * w)) & m;
      lane_oe_out = rx ? 4'h0 : m;
      #48 g = (rx && w == 1) ? lane_in >> 1 : lane_in;
      r = (r << w) | 8'(g & m);
      sck_out = 1'b1;
      #32;
    end
  endtask
  // Double rate: one nibble on all four lanes at each clock edge
  task ddr(input logic [7:0] b);
    for (int i = 1; i >= 0; i--) begin
      lane_out = 4'(b >> (i * 4));
      lane_oe_out = 4'hf;
      #24 sck_out = ~sck_out;
      #16;
    end
  endtask
  // Clock stands at its idle level while deselected
  task stop;
    sck_out = mode3;
    lane_oe_out = 4'h0;
    #48 cs_n_out = 1'b1;
    #200;
  endtask
endmodule

// file: tb/mlsp_serial_port_test.sv
`timescale 1ns/1ps
module mlsp_serial_port_test;
  logic        sys_clk_in, rst_in, wp_n, hr_n, cfg_we, cs_n, sck;
  logic        cv, av, wv, blk, blk_q, two, four, sb, hw, hadr, wide, rd, sw, dd, rq;
  logic [1:0]  dl;
  logic [3:0]  d_o, d_e, m_o, m_e, ln, dm;
  logic [7:0]  sr1, nv, cfg_d, rd_d, opc, wd, opc_q, wd_q, r;
  logic [20:0] adr, adr_q;
  logic [31:0] lfsr, a;
  logic [7:0]  rop [4] = '{8'h03, 8'h6b, 8'hbb, 8'heb};
  int          dwid [4] = '{1, 4, 2, 4};
  int          awid [4] = '{1, 1, 2, 4};
  int          fail_count, tests_run, nwr, n0, nrq;

  mlsp_serial_port u_mlsp_serial_port (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .cs_n_in(cs_n), .sck_in(sck),
    .lane_zero_in(ln[0]), .lane_one_in(ln[1]), .lane_two_in(ln[2]), .lane_three_in(ln[3]),
    .lane_zero_out(d_o[0]), .lane_zero_oe_out(d_e[0]), .lane_one_out(d_o[1]), .lane_one_oe_out(d_e[1]),
    .lane_two_out(d_o[2]), .lane_two_oe_out(d_e[2]), .lane_three_out(d_o[3]), .lane_three_oe_out(d_e[3]),
    .first_status_register_in(sr1), .second_config_register_nv_in(nv), .cfg_vol_we_in(cfg_we),
    .cfg_vol_data_in(cfg_d), .two_lane_all_phase_protocol_out(two),
    .four_lane_all_phase_protocol_out(four), .standby_out(sb), .hw_reset_out(hw),
    .cmd_valid_out(cv), .cmd_opcode_out(opc), .dec_has_addr_in(hadr), .dec_addr_wide_in(wide),
    .dec_data_lanes_in(dl), .dec_ddr_in(dd), .dec_read_in(rd), .dec_dummy_in(dm),
    .dec_status_write_in(sw), .addr_valid_out(av), .addr_out(adr), .wr_valid_out(wv),
    .wr_data_out(wd), .rd_req_out(rq), .rd_data_in(rd_d), .reg_write_blocked_out(blk)
  );
  mlsp_master_model u_mlsp_master_model (
    .cs_n_out(cs_n), .sck_out(sck), .lane_out(m_o), .lane_oe_out(m_e), .lane_in(ln)
  );
  // Released data lanes show the inverse, protect and reset pins idle high
  assign ln = (d_e & d_o) | (~d_e & m_e & m_o) | (~d_e & ~m_e & {hr_n, wp_n, ~m_o[1:0]});

  always @* begin
    {hadr, wide, dl, rd, sw, dd, dm} = 11'h000;
    case (opc)
      8'h02: hadr = 1'b1;
      8'h03: {hadr, rd} = 2'h3;
      8'h6b: {hadr, rd, dl} = 4'he;
      8'hbb: {hadr, wide, rd, dl} = 5'h1d;
      8'h01: sw = 1'b1;
      8'heb: {hadr, wide, rd, dl, dm} = 9'h1e4;
      8'hde: {hadr, wide, dl, dd} = 5'h1d;
      default: hadr = 1'b0;
    endcase
  end
  always @(posedge sys_clk_in) begin
    if (cv) opc_q <= opc;
    if (av) adr_q <= adr;
    if (blk) blk_q <= 1'b1;
    if (rq) nrq <= nrq + 1;
    if (wv) begin
      wd_q <= wd;
      nwr <= nwr + 1;
    end
  end

  initial begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end
  initial begin
    #400000;
    fail_count++;
    end_of_test();
  end

  function logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task txn(input logic m3, input logic [7:0] op, input int ow, input int aw, input int dw, input logic rx);
    u_mlsp_master_model.start(m3);
    u_mlsp_master_model.xfer(op, ow, 1'b0, r);
    if (op != 8'h01) begin
      for (int k = 2; k >= 0; k--) begin
        if (dd)
          u_mlsp_master_model.ddr(a[k * 8 +: 8]);
        else
          u_mlsp_master_model.xfer(a[k * 8 +: 8], aw, 1'b0, r);
      end
    end
    // Dummy clocks with the lanes released, one clock per unit of a padding byte
    if (dm != 4'h0)
      u_mlsp_master_model.xfer(8'h00, 8 / dm, 1'b1, r);
    if (dd)
      u_mlsp_master_model.ddr(a[31:24]);
    else
      u_mlsp_master_model.xfer(a[31:24], dw, rx, r);
    u_mlsp_master_model.stop();
  endtask
  task cfgw(input logic [7:0] v);
    @(negedge sys_clk_in) cfg_we = 1'b1;
    cfg_d = v;
    @(negedge sys_clk_in) cfg_we = 1'b0;
    repeat (2) @(negedge sys_clk_in);
  endtask
  task end_of_test;
    if (fail_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    {rst_in, wp_n, hr_n} = 3'h7;
    {cfg_we, cfg_d, sr1, blk_q, rd_d} = 26'h0;
    {fail_count, tests_run, nwr, nrq} = '0;
    lfsr = 32'hcc57;
    nv = 8'(rnd()) & 8'haf;
    repeat (3) @(posedge sys_clk_in);
    @(negedge sys_clk_in) rst_in = 1'b0;
    repeat (4) @(negedge sys_clk_in);
    // Writes in both clock modes, address top bits set
    for (int m = 0; m < 2; m++) begin
      a = rnd() | 32'h00e0_0000;
      txn(m[0], 8'h02, 1, 1, 1, 1'b0);
      chk(opc_q, 8'h02);
      chk(adr_q, a[20:0]);
      chk(wd_q, a[31:24]);
    end
    // Four-lane double rate write: opcode at single rate, address and data on both edges
    a = rnd();
    txn(1'b0, 8'hde, 1, 4, 4, 1'b0);
    chk(opc_q, 8'hde);
    chk(adr_q, a[20:0]);
    chk(wd_q, a[31:24]);
    // Reads on one, four and two lanes, then four-lane address with dummy clocks
    for (int k = 0; k < 4; k++) begin
      a = rnd();
      rd_d = 8'(rnd());
      n0 = nrq;
      txn(1'b0, rop[k], 1, awid[k], dwid[k], 1'b1);
      chk(r, rd_d);
      chk(nrq, n0 + 2);
    end
    // Status writes with and without protection
    n0 = nwr;
    sr1 = 8'(rnd()) | 8'h80;
    wp_n = 1'b0;
    txn(1'b0, 8'h01, 1, 1, 1, 1'b0);
    chk(nwr, n0);
    chk(blk_q, 1'b1);
    cfgw(8'h10);
    chk(two, 1'b0);
    wp_n = 1'b1;
    blk_q = 1'b0;
    txn(1'b0, 8'h01, 1, 1, 1, 1'b0);
    chk(nwr, n0 + 1);
    chk(blk_q, 1'b0);
    cfgw(8'h10);
    chk(two, 1'b1);
    // Two-lane all-phase write
    a = rnd();
    txn(1'b0, 8'h02, 2, 2, 2, 1'b0);
    chk(adr_q, a[20:0]);
    chk(wd_q, a[31:24]);
    // Reset pin pulse reloads config and returns to one lane
    hr_n = 1'b0;
    repeat (8) @(negedge sys_clk_in);
    chk(hw, 1'b1);
    chk(d_e, 4'h0);
    hr_n = 1'b1;
    repeat (6) @(negedge sys_clk_in);
    chk(two, nv[4]);
    chk(four, nv[6]);
    a = rnd();
    txn(1'b1, 8'h02, 1, 1, 1, 1'b0);
    chk(wd_q, a[31:24]);
    end_of_test();
  end
endmodule
